// ### rtl/cifd_pkg.sv
/*
  cifd_pkg: opcodes, masks, register offsets, field positions,
  reset values, state and operation encodings and carrier structs
  for the control / inherent / pointer instruction executor.
  Assumes a 14-bit instruction word and a 15-bit program counter.
*/
package cifd_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int PC_W = 15;
  localparam int IW_W = 14;
  localparam int PTR_W = 16;
  localparam int RA_W = 5;

  // ----------------------------------------------------------------
  // opcodes, exact matches and pattern / mask pairs
  // ----------------------------------------------------------------
  localparam logic [13:0] OP_BRW       = 14'h000b;
  localparam logic [13:0] OP_CALL_VIA_WREG     = 14'h000a;
  localparam logic [13:0] OP_OPTION    = 14'h0062;
  localparam logic [13:0] OP_SLEEP     = 14'h0063;
  localparam logic [13:0] OP_WDT_CLR   = 14'h0064;
  localparam logic [13:0] PAT_PORT_DIRECTION_LOAD     = 14'h0060;
  localparam logic [13:0] PAT_LD_MM    = 14'h0010;
  localparam logic [13:0] PAT_ST_MM    = 14'h0018;
  localparam logic [13:0] MSK_3BIT     = 14'h3ff8;
  localparam logic [13:0] PAT_RETLIT   = 14'h3400;
  localparam logic [13:0] PAT_ADDLIT   = 14'h3e00;
  localparam logic [13:0] PAT_ANDF     = 14'h0500;
  localparam logic [13:0] PAT_ADDF     = 14'h0700;
  localparam logic [13:0] MSK_BYTE     = 14'h3f00;
  localparam logic [13:0] PAT_PTR_ADD  = 14'h3100;
  localparam logic [13:0] PAT_LD_IDX   = 14'h3f00;
  localparam logic [13:0] PAT_ST_IDX   = 14'h3f80;
  localparam logic [13:0] MSK_7BIT     = 14'h3f80;

  // ----------------------------------------------------------------
  // register offsets on the software port
  // ----------------------------------------------------------------
  localparam logic [4:0] RA_WREG    = 5'h00;
  localparam logic [4:0] RA_STATUS  = 5'h01;
  localparam logic [4:0] RA_PTR0_LO = 5'h02;
  localparam logic [4:0] RA_PTR0_HI = 5'h03;
  localparam logic [4:0] RA_PTR1_LO = 5'h04;
  localparam logic [4:0] RA_PTR1_HI = 5'h05;
  localparam logic [4:0] RA_OPTION  = 5'h06;
  localparam logic [4:0] RA_PCHI    = 5'h07;
  localparam logic [4:0] RA_STATE   = 5'h08;
  localparam logic [1:0] RA_PORT_DIRECTION_LOAD_HI = 2'h2;

  // ----------------------------------------------------------------
  // status fields and reset values
  // ----------------------------------------------------------------
  localparam int ST_C  = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z  = 2;
  localparam int ST_PD = 3;
  localparam int ST_TO = 4;
  localparam logic [4:0] STATUS_RST = 5'h18;
  localparam logic [7:0] OPTION_RST = 8'hff;
  localparam logic [7:0] PORT_DIRECTION_LOAD_RST   = 8'hff;

  // ----------------------------------------------------------------
  // encodings and carriers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_ISSUE = 3'b001,
    S_DATA  = 3'b010,
    S_EXTRA = 3'b011,
    S_FLUSH = 3'b100,
    S_SLEEP = 3'b101
  } cifd_state_e;

  typedef enum logic [1:0] {
    K_LOAD = 2'b00,
    K_AND  = 2'b01,
    K_ADD  = 2'b10,
    K_NONE = 2'b11
  } cifd_op_e;

  typedef struct packed {
    logic             rd;
    logic             wr;
    logic [PTR_W-1:0] addr;
    logic [7:0]       wdata;
  } cifd_dm_req_s;

  typedef struct packed {
    logic            load;
    logic            push;
    logic            pop;
    logic [PC_W-1:0] target;
    logic [PC_W-1:0] ret_addr;
  } cifd_pc_ctrl_s;

endpackage : cifd_pkg

// ### rtl/cifd_core.sv
/*
  cifd_core: executes control transfers, inherent operations, pointer
  arithmetic with indirect load / store, and the literal / file adds
  and AND of an 8-bit core with 14-bit instructions.
  Assumes the fetch path offers one instruction with its own address
  and honours INSTR_READY, and the data memory answers a read one
  cycle after its strobe.
*/
`timescale 1ns/1ns
module cifd_core
  import cifd_pkg::*;
#(
  parameter int PORT_DIRECTION_LOAD_COUNT = 8
)(
  input  wire logic                       SYS_CLK,
  input  wire logic                       RESET,
  input  wire logic                       INSTR_VALID,
  input  wire logic [IW_W-1:0]            INSTR_WORD,
  input  wire logic [PC_W-1:0]            INSTR_PC,
  output var  logic                       INSTR_READY,
  output var  cifd_dm_req_s               DM_REQ,
  input  wire logic [7:0]                 DM_RDATA,
  output var  cifd_pc_ctrl_s              PC_CTRL,
  input  wire logic                       WAKE,
  output var  logic                       SLEEPING,
  output var  logic [7:0]                 OPTION_VALUE,
  output var  logic [PORT_DIRECTION_LOAD_COUNT-1:0][7:0] PORT_DIRECTION_LOAD_DIR,
  input  wire logic [RA_W-1:0]            REG_ADDR,
  input  wire logic [7:0]                 REG_WDATA,
  input  wire logic                       REG_WR,
  input  wire logic                       REG_RD,
  output var  logic [7:0]                 REG_RDATA
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (PORT_DIRECTION_LOAD_COUNT < 1 || PORT_DIRECTION_LOAD_COUNT > 8) begin : g_bad_count
    $error("PORT_DIRECTION_LOAD_COUNT must lie in 1..8");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cifd_state_e                  state_ff, nxt_state;
  cifd_op_e                     op_ff, nxt_op;
  logic [7:0]                   w_ff, nxt_w;
  logic [4:0]                   status_ff, nxt_status;
  logic [1:0][PTR_W-1:0]        ptr_ff, nxt_ptr;
  logic [7:0]                   option_ff, nxt_option;
  logic [6:0]                   pchi_ff, nxt_pchi;
  logic [PORT_DIRECTION_LOAD_COUNT-1:0][7:0]   port_direction_load_ff, nxt_port_direction_load;
  logic [PTR_W-1:0]             addr_ff, nxt_addr;
  logic                         dest_ff, nxt_dest;
  logic                         ready_ff, nxt_ready;
  cifd_dm_req_s                 dm_ff, nxt_dm;
  cifd_pc_ctrl_s                pc_ff, nxt_pc;
  logic [7:0]                   rdata_ff, nxt_rdata;
  logic                         acc_ind_ff;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire logic [13:0] iw       = INSTR_WORD;
  wire logic        take     = INSTR_VALID & ready_ff;
  wire logic        is_brw   = iw == OP_BRW;
  wire logic        is_call_via_wreg = iw == OP_CALL_VIA_WREG;
  wire logic        is_opt   = iw == OP_OPTION;
  wire logic        is_sleep = iw == OP_SLEEP;
  wire logic        is_port_direction_load  = (iw & MSK_3BIT) == PAT_PORT_DIRECTION_LOAD && !is_opt && !is_sleep && iw != OP_WDT_CLR;
  wire logic        is_ldmm  = (iw & MSK_3BIT) == PAT_LD_MM;
  wire logic        is_stmm  = (iw & MSK_3BIT) == PAT_ST_MM;
  wire logic        is_ret   = (iw & MSK_BYTE) == PAT_RETLIT;
  wire logic        is_addl  = (iw & MSK_BYTE) == PAT_ADDLIT;
  wire logic        is_andf  = (iw & MSK_BYTE) == PAT_ANDF;
  wire logic        is_addf  = (iw & MSK_BYTE) == PAT_ADDF;
  wire logic        is_padd  = (iw & MSK_7BIT) == PAT_PTR_ADD;
  wire logic        is_ldix  = (iw & MSK_7BIT) == PAT_LD_IDX;
  wire logic        is_stix  = (iw & MSK_7BIT) == PAT_ST_IDX;

  // ----------------------------------------------------------------
  // pointer address arithmetic
  // ----------------------------------------------------------------
  wire logic [PTR_W-1:0] ptr_mm   = ptr_ff[iw[2]];
  wire logic [PTR_W-1:0] ptr_step = iw[0] ? 16'hffff : 16'h0001;
  wire logic [PTR_W-1:0] ptr_mod  = ptr_mm + ptr_step;
  wire logic [PTR_W-1:0] mm_addr  = iw[1] ? ptr_mm : ptr_mod;
  wire logic [PTR_W-1:0] k_ext    = {{10{iw[5]}}, iw[5:0]};
  wire logic [PTR_W-1:0] ptr_k    = ptr_ff[iw[6]];
  wire logic [PTR_W-1:0] idx_sum  = ptr_k + k_ext;
  wire logic             f_indf   = iw[6:1] == 6'h00;
  wire logic [PTR_W-1:0] f_addr   = f_indf ? ptr_ff[iw[0]] : {9'h000, iw[6:0]};
  wire logic [PTR_W-1:0] acc_addr = is_ldmm || is_stmm ? mm_addr : (is_ldix || is_stix ? idx_sum : f_addr);
  wire logic             acc_ind  = is_ldmm | is_stmm | is_ldix | is_stix | f_indf;
  wire logic             acc_slow = acc_ind & acc_addr[PTR_W-1];

  // ----------------------------------------------------------------
  // arithmetic
  // ----------------------------------------------------------------
  wire logic [7:0] alu_b   = state_ff == S_DATA ? DM_RDATA : iw[7:0];
  wire logic [8:0] sum9    = {1'b0, w_ff} + {1'b0, alu_b};
  wire logic [4:0] sum_lo  = {1'b0, w_ff[3:0]} + {1'b0, alu_b[3:0]};
  wire logic [7:0] and_res = w_ff & DM_RDATA;
  wire logic [PC_W-1:0] brw_tgt = INSTR_PC + 15'd1 + {7'h00, w_ff};
  wire logic [PC_W-1:0] ret_pc  = INSTR_PC + 15'd1;
  wire logic [7:0] data_res = op_ff == K_AND ? and_res : (op_ff == K_ADD ? sum9[7:0] : DM_RDATA);

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  wire logic       port_direction_load_hit = REG_ADDR[4:3] == RA_PORT_DIRECTION_LOAD_HI && 32'(REG_ADDR[2:0]) < PORT_DIRECTION_LOAD_COUNT;
  wire logic [7:0] rd_mux   =
    REG_ADDR == RA_WREG    ? w_ff :
    REG_ADDR == RA_STATUS  ? {3'h0, status_ff} :
    REG_ADDR == RA_PTR0_LO ? ptr_ff[0][7:0] :
    REG_ADDR == RA_PTR0_HI ? ptr_ff[0][15:8] :
    REG_ADDR == RA_PTR1_LO ? ptr_ff[1][7:0] :
    REG_ADDR == RA_PTR1_HI ? ptr_ff[1][15:8] :
    REG_ADDR == RA_OPTION  ? option_ff :
    REG_ADDR == RA_PCHI    ? {1'b0, pchi_ff} :
    REG_ADDR == RA_STATE   ? {4'h0, state_ff == S_SLEEP, state_ff} :
    port_direction_load_hit               ? port_direction_load_ff[REG_ADDR[2:0]] : 8'h00;

  // ----------------------------------------------------------------
  // next state; software writes first, core updates override
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state  = state_ff;
    nxt_op     = op_ff;
    nxt_w      = w_ff;
    nxt_status = status_ff;
    nxt_ptr    = ptr_ff;
    nxt_option = option_ff;
    nxt_pchi   = pchi_ff;
    nxt_port_direction_load   = port_direction_load_ff;
    nxt_addr   = addr_ff;
    nxt_dest   = dest_ff;
    nxt_dm     = '0;
    nxt_pc     = '0;
    nxt_rdata  = REG_RD ? rd_mux : 8'h00;
    if (REG_WR) begin
      case (REG_ADDR)
        RA_WREG:    nxt_w = REG_WDATA;
        RA_STATUS:  nxt_status = REG_WDATA[4:0];
        RA_PTR0_LO: nxt_ptr[0][7:0] = REG_WDATA;
        RA_PTR0_HI: nxt_ptr[0][15:8] = REG_WDATA;
        RA_PTR1_LO: nxt_ptr[1][7:0] = REG_WDATA;
        RA_PTR1_HI: nxt_ptr[1][15:8] = REG_WDATA;
        RA_OPTION:  nxt_option = REG_WDATA;
        RA_PCHI:    nxt_pchi = REG_WDATA[6:0];
        default: begin
          if (port_direction_load_hit) begin
            nxt_port_direction_load[REG_ADDR[2:0]] = REG_WDATA;
          end
        end
      endcase
    end
    case (state_ff)
      S_IDLE: begin
        if (take) begin
          if (is_brw) begin
            nxt_pc.load   = 1'b1;
            nxt_pc.target = brw_tgt;
            nxt_state     = S_FLUSH;
          end else if (is_call_via_wreg) begin
            nxt_pc.load     = 1'b1;
            nxt_pc.push     = 1'b1;
            nxt_pc.ret_addr = ret_pc;
            nxt_pc.target   = {pchi_ff, w_ff};
            nxt_state       = S_FLUSH;
          end else if (is_ret) begin
            nxt_pc.pop = 1'b1;
            nxt_w      = iw[7:0];
            nxt_state  = S_FLUSH;
          end else if (is_opt) begin
            nxt_option = w_ff;
          end else if (is_port_direction_load) begin
            if (32'(iw[2:0]) < PORT_DIRECTION_LOAD_COUNT) begin
              nxt_port_direction_load[iw[2:0]] = w_ff;
            end
          end else if (is_sleep) begin
            nxt_status[ST_TO] = 1'b1;
            nxt_status[ST_PD] = 1'b0;
            nxt_state         = S_SLEEP;
          end else if (is_padd) begin
            nxt_ptr[iw[6]] = idx_sum;
          end else if (is_addl) begin
            nxt_w              = sum9[7:0];
            nxt_status[ST_C]   = sum9[8];
            nxt_status[ST_DC]  = sum_lo[4];
            nxt_status[ST_Z]   = sum9[7:0] == 8'h00;
          end else if (is_stmm || is_stix) begin
            nxt_dm.wr    = 1'b1;
            nxt_dm.addr  = acc_addr;
            nxt_dm.wdata = w_ff;
            if (is_stmm) begin
              nxt_ptr[iw[2]] = ptr_mod;
            end
            nxt_state = acc_slow ? S_EXTRA : S_IDLE;
          end else if (is_ldmm || is_ldix || is_andf || is_addf) begin
            nxt_dm.rd  = 1'b1;
            nxt_dm.addr = acc_addr;
            nxt_addr   = acc_addr;
            nxt_dest   = (is_andf | is_addf) & iw[7];
            nxt_op     = is_andf ? K_AND : (is_addf ? K_ADD : K_LOAD);
            if (is_ldmm) begin
              nxt_ptr[iw[2]] = ptr_mod;
            end
            nxt_state = S_ISSUE;
          end
        end
      end
      S_ISSUE: begin
        nxt_state = S_DATA;
      end
      S_DATA: begin
        if (dest_ff) begin
          nxt_dm.wr    = 1'b1;
          nxt_dm.addr  = addr_ff;
          nxt_dm.wdata = data_res;
        end else begin
          nxt_w = data_res;
        end
        nxt_status[ST_Z] = data_res == 8'h00;
        if (op_ff == K_ADD) begin
          nxt_status[ST_C]  = sum9[8];
          nxt_status[ST_DC] = sum_lo[4];
        end
        nxt_op    = K_NONE;
        nxt_state = addr_ff[PTR_W-1] && acc_ind_ff ? S_EXTRA : S_IDLE;
      end
      S_EXTRA: begin
        nxt_state = S_IDLE;
      end
      S_FLUSH: begin
        nxt_state = S_IDLE;
      end
      S_SLEEP: begin
        if (WAKE) begin
          nxt_state = S_IDLE;
        end
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase
    nxt_ready = nxt_state == S_IDLE;
  end

  // ----------------------------------------------------------------
  // indirect marker for the pending read
  // ----------------------------------------------------------------
  wire logic nxt_acc_ind = state_ff == S_IDLE && take ? acc_ind : acc_ind_ff;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      state_ff   <= S_IDLE;
      op_ff      <= K_NONE;
      w_ff       <= 8'h00;
      status_ff  <= STATUS_RST;
      ptr_ff     <= '0;
      option_ff  <= OPTION_RST;
      pchi_ff    <= 7'h00;
      port_direction_load_ff    <= {PORT_DIRECTION_LOAD_COUNT{PORT_DIRECTION_LOAD_RST}};
      addr_ff    <= 16'h0000;
      dest_ff    <= 1'b0;
      acc_ind_ff <= 1'b0;
      ready_ff   <= 1'b1;
      dm_ff      <= '0;
      pc_ff      <= '0;
      rdata_ff   <= 8'h00;
    end else begin
      state_ff   <= nxt_state;
      op_ff      <= nxt_op;
      w_ff       <= nxt_w;
      status_ff  <= nxt_status;
      ptr_ff     <= nxt_ptr;
      option_ff  <= nxt_option;
      pchi_ff    <= nxt_pchi;
      port_direction_load_ff    <= nxt_port_direction_load;
      addr_ff    <= nxt_addr;
      dest_ff    <= nxt_dest;
      acc_ind_ff <= nxt_acc_ind;
      ready_ff   <= nxt_ready;
      dm_ff      <= nxt_dm;
      pc_ff      <= nxt_pc;
      rdata_ff   <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // sleep marker and outputs
  // ----------------------------------------------------------------
  logic sleep_ff;

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      sleep_ff <= 1'b0;
    end else begin
      sleep_ff <= nxt_state == S_SLEEP;
    end
  end

  assign INSTR_READY  = ready_ff;
  assign DM_REQ       = dm_ff;
  assign PC_CTRL      = pc_ff;
  assign SLEEPING     = sleep_ff;
  assign OPTION_VALUE = option_ff;
  assign PORT_DIRECTION_LOAD_DIR     = port_direction_load_ff;
  assign REG_RDATA    = rdata_ff;

endmodule : cifd_core

// ### tb/cifd_core_assertions.sv
/*
  cifd_checker: port-level assertions for cifd_core.
  Assumes it is bound to every cifd_core instance, one clock domain.
*/
`timescale 1ns/1ns
module cifd_checker
  import cifd_pkg::*;
(
  input wire logic            SYS_CLK,
  input wire logic            RESET,
  input wire logic            INSTR_VALID,
  input wire logic [IW_W-1:0] INSTR_WORD,
  input wire logic [PC_W-1:0] INSTR_PC,
  input wire logic            INSTR_READY,
  input wire cifd_dm_req_s    DM_REQ,
  input wire cifd_pc_ctrl_s   PC_CTRL,
  input wire logic            SLEEPING
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  wire       take = INSTR_VALID && INSTR_READY;
  wire [13:0] iw  = INSTR_WORD;

  branch_w_a:
    assert property (take && iw == OP_BRW |=> PC_CTRL.load && !INSTR_READY ##1 INSTR_READY)
    else $error("branch via w timing wrong");
  call_w_a:
    assert property (take && iw == OP_CALL_VIA_WREG |=> PC_CTRL.load && PC_CTRL.push
      && PC_CTRL.ret_addr == $past(INSTR_PC) + 15'h0001 ##1 INSTR_READY)
    else $error("call via w wrong");
  ret_lit_a:
    assert property (take && (iw & MSK_BYTE) == PAT_RETLIT |=> PC_CTRL.pop && !INSTR_READY ##1 INSTR_READY)
    else $error("return with literal wrong");
  one_cycle_a:
    assert property (take && iw != OP_SLEEP && ((iw & MSK_3BIT) == PAT_PORT_DIRECTION_LOAD
      || (iw & MSK_BYTE) == PAT_ADDLIT || (iw & MSK_BYTE) == PAT_PTR_ADD)
      |=> INSTR_READY && !DM_REQ.rd && !DM_REQ.wr)
    else $error("single cycle op stalled");
  sleep_entry_a:
    assert property (take && iw == OP_SLEEP |=> SLEEPING && !INSTR_READY)
    else $error("sleep not entered");
  store_req_a:
    assert property (take && ((iw & MSK_3BIT) == PAT_ST_MM || (iw & MSK_7BIT) == PAT_ST_IDX)
      |=> DM_REQ.wr && !DM_REQ.rd)
    else $error("store without write");
  load_req_a:
    assert property (take && ((iw & MSK_3BIT) == PAT_LD_MM || (iw & MSK_7BIT) == PAT_LD_IDX) |=> DM_REQ.rd)
    else $error("load without read");
  rd_extra_a:
    assert property (DM_REQ.rd |-> ##2 (INSTR_READY != $past(DM_REQ.addr[15], 2)))
    else $error("read extra cycle wrong");
  wr_extra_a:
    assert property (DM_REQ.wr |-> (INSTR_READY != DM_REQ.addr[15]) ##1 (INSTR_READY || $past(INSTR_READY)))
    else $error("write extra cycle wrong");
  file_dest_a:
    assert property (take && ((iw & MSK_BYTE) == PAT_ADDF || (iw & MSK_BYTE) == PAT_ANDF)
      |=> DM_REQ.rd ##2 (DM_REQ.wr == $past(INSTR_WORD[7], 3)))
    else $error("file destination wrong");
endmodule : cifd_checker

bind cifd_core cifd_checker u_chk (.SYS_CLK(SYS_CLK), .RESET(RESET), .INSTR_VALID(INSTR_VALID),
  .INSTR_WORD(INSTR_WORD), .INSTR_PC(INSTR_PC), .INSTR_READY(INSTR_READY), .DM_REQ(DM_REQ),
  .PC_CTRL(PC_CTRL), .SLEEPING(SLEEPING));

// ### tb/cifd_dmem_model.sv
/*
  cifd_dmem_model: data memory behind the core's data port.
  Assumes read data wanted only in the cycle after a read strobe.
*/
`timescale 1ns/1ns
module cifd_dmem_model
  import cifd_pkg::*;
(
  input  wire logic         clk,
  input  wire cifd_dm_req_s req,
  output var  logic [7:0]   rdata
);
  logic [7:0] mem [0:65535];
  // unwritten cells read addr low byte xor 3c; idle cycles toggle data
  initial begin
    rdata = 8'h00;
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'(i) ^ 8'h3c;
    end
  end
  always @(posedge clk) begin
    if (req.wr) begin
      mem[req.addr] <= req.wdata;
    end
    if (req.rd) begin
      rdata <= mem[req.addr];
    end else begin
      rdata <= ~rdata;
    end
  end
endmodule : cifd_dmem_model

// ### tb/tb_top.sv
/*
  tb_top: self-checking bench for cifd_core.
  Assumes cifd_dmem_model as data memory and the bound checker.
*/
`timescale 1ns/1ns
module tb_top
  import cifd_pkg::*;
;
  logic            sys_clk = 1'b0;
  logic            reset = 1'b1;
  logic            instr_valid = 1'b0;
  logic            reg_wr = 1'b0;
  logic            reg_rd = 1'b0;
  logic            wake = 1'b0;
  logic [13:0]     instr_word = 14'h0000;
  logic [14:0]     instr_pc = 15'h0000;
  logic [4:0]      reg_addr = 5'h00;
  logic [7:0]      reg_wdata = 8'h00;
  logic [7:0]      dm_rdata, reg_rdata, option_value;
  logic [7:0][7:0] port_direction_load_dir;
  logic            instr_ready, sleeping, sleep_seen;
  cifd_dm_req_s    dm_req, dm_seen;
  cifd_pc_ctrl_s   pc_ctrl, pc_seen;
  int              errors = 0;
  int              checks = 0;
  int              ncyc;

  always #2 sys_clk = ~sys_clk;

  cifd_core dut (.SYS_CLK(sys_clk), .RESET(reset), .INSTR_VALID(instr_valid), .INSTR_WORD(instr_word),
    .INSTR_PC(instr_pc), .INSTR_READY(instr_ready), .DM_REQ(dm_req), .DM_RDATA(dm_rdata),
    .PC_CTRL(pc_ctrl), .WAKE(wake), .SLEEPING(sleeping), .OPTION_VALUE(option_value),
    .PORT_DIRECTION_LOAD_DIR(port_direction_load_dir), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata));
  cifd_dmem_model dmem (.clk(sys_clk), .req(dm_req), .rdata(dm_rdata));

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic cmp(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp

  task automatic reg_w(input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : reg_w

  task automatic reg_c(input logic [4:0] a, input logic [7:0] exp, input string nm);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    cmp(nm, {8'h00, exp}, {8'h00, reg_rdata});
  endtask : reg_c

  task automatic ptr_w(input logic [4:0] a, input logic [15:0] v);
    reg_w(a, v[7:0]);
    reg_w(a + 5'h01, v[15:8]);
  endtask : ptr_w

  task automatic ptr_c(input logic [4:0] a, input logic [15:0] v);
    reg_c(a, v[7:0], "ptr lo");
    reg_c(a + 5'h01, v[15:8], "ptr hi");
  endtask : ptr_c

  task automatic exec(input logic [13:0] iw);
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr_word <= iw;
    instr_pc <= instr_pc + 15'h0040;
    do @(negedge sys_clk); while (instr_ready !== 1'b1);
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    dm_seen = '0;
    ncyc = 0;
    do begin
      @(negedge sys_clk);
      ncyc++;
      if (ncyc == 1) begin
        pc_seen = pc_ctrl;
        sleep_seen = sleeping;
      end
      if (dm_req.rd || dm_req.wr) begin
        dm_seen = dm_req;
      end
    end while (instr_ready !== 1'b1 && ncyc < 20);
  endtask : exec

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_inherent;
    reg_c(RA_STATUS, 8'h18, "status rst");
    reg_c(5'h1f, 8'h00, "unmapped");
    cmp("option rst", 16'h00ff, {8'h00, option_value});
    reg_w(RA_WREG, 8'h5a);
    exec(OP_OPTION);
    cmp("option", 16'h005a, {8'h00, option_value});
    exec(PAT_PORT_DIRECTION_LOAD | 14'h0005);
    cmp("tris5", 16'h005a, {8'h00, port_direction_load_dir[5]});
    cmp("tris4", 16'h00ff, {8'h00, port_direction_load_dir[4]});
    cmp("port_direction_load cycles", 16'h0001, ncyc[15:0]);
    $display("test reset_inherent done");
  endtask : t_reset_inherent

  task automatic t_control;
    reg_w(RA_WREG, 8'h05);
    instr_pc <= 15'h00c0;
    exec(OP_BRW);
    cmp("brw target", 16'h0106, {1'b0, pc_seen.target});
    cmp("brw load", 16'h0001, {15'h0000, pc_seen.load});
    cmp("brw cycles", 16'h0002, ncyc[15:0]);
    reg_w(RA_PCHI, 8'h12);
    reg_w(RA_WREG, 8'h34);
    exec(OP_CALL_VIA_WREG);
    cmp("call target", 16'h1234, {1'b0, pc_seen.target});
    cmp("call push", 16'h0001, {15'h0000, pc_seen.push});
    cmp("call ret", 16'h0141, {1'b0, pc_seen.ret_addr});
    exec(PAT_RETLIT | 14'h00a5);
    cmp("ret pop", 16'h0001, {15'h0000, pc_seen.pop});
    cmp("ret cycles", 16'h0002, ncyc[15:0]);
    reg_c(RA_WREG, 8'ha5, "ret w");
    $display("test control done");
  endtask : t_control

  task automatic t_arith_ptr;
    reg_w(RA_WREG, 8'h8f);
    exec(PAT_ADDLIT | 14'h0071);
    reg_c(RA_WREG, 8'h00, "add_literal_op w");
    reg_c(RA_STATUS, 8'h1f, "add_literal_op flags");
    reg_w(RA_WREG, 8'h08);
    exec(PAT_ADDLIT | 14'h0008);
    reg_c(RA_STATUS, 8'h1a, "add_literal_op dc");
    ptr_w(RA_PTR0_LO, 16'hffff);
    exec(PAT_PTR_ADD | 14'h0001);
    ptr_c(RA_PTR0_LO, 16'h0000);
    ptr_w(RA_PTR1_LO, 16'h0000);
    exec(PAT_PTR_ADD | 14'h0060);
    ptr_c(RA_PTR1_LO, 16'hffe0);
    reg_c(RA_STATUS, 8'h1a, "ptr add flags");
    $display("test arith_ptr done");
  endtask : t_arith_ptr

  task automatic t_indirect;
    ptr_w(RA_PTR0_LO, 16'h003c);
    exec(PAT_LD_MM | 14'h0002);
    cmp("ld addr", 16'h003c, dm_seen.addr);
    reg_c(RA_WREG, 8'h00, "ld w");
    reg_c(RA_STATUS, 8'h1e, "ld zero");
    ptr_c(RA_PTR0_LO, 16'h003d);
    exec(PAT_LD_IDX | 14'h0001);
    reg_c(RA_WREG, 8'h02, "ldi w");
    reg_c(RA_STATUS, 8'h1a, "ldi zero");
    reg_w(RA_WREG, 8'h77);
    ptr_w(RA_PTR1_LO, 16'h8001);
    exec(PAT_ST_MM | 14'h0005);
    cmp("st addr", 16'h8000, dm_seen.addr);
    cmp("st data", 16'h0077, {8'h00, dm_seen.wdata});
    cmp("st extra", 16'h0002, ncyc[15:0]);
    reg_c(RA_STATUS, 8'h1a, "st flags");
    exec(PAT_ST_IDX | 14'h003f);
    cmp("sti addr", 16'h003c, dm_seen.addr);
    cmp("sti cycles", 16'h0001, ncyc[15:0]);
    exec(PAT_LD_MM | 14'h0006);
    cmp("ld slow", 16'h0004, ncyc[15:0]);
    reg_c(RA_WREG, 8'h77, "ld stored");
    ptr_c(RA_PTR1_LO, 16'h8001);
    $display("test indirect done");
  endtask : t_indirect

  task automatic t_file_sleep;
    reg_w(RA_WREG, 8'h05);
    exec(PAT_ADDF | 14'h00a0);
    cmp("addf wr", 16'h0121, {7'h00, dm_seen.wr, dm_seen.wdata});
    reg_c(RA_STATUS, 8'h1a, "addf flags");
    reg_c(RA_WREG, 8'h05, "addf w");
    exec(PAT_ANDF | 14'h0036);
    cmp("andf rd", 16'h0036, {dm_seen.wr, dm_seen.addr[14:0]});
    reg_c(RA_WREG, 8'h00, "andf w");
    reg_c(RA_STATUS, 8'h1e, "andf flags");
    exec(OP_SLEEP);
    cmp("sleeping", 16'h0001, {15'h0000, sleep_seen});
    cmp("sleep hold", 16'h0001, {15'h0000, sleeping});
    @(posedge sys_clk);
    wake <= 1'b1;
    @(posedge sys_clk);
    wake <= 1'b0;
    @(negedge sys_clk);
    cmp("woken", 16'h0001, {15'h0000, instr_ready});
    reg_c(RA_STATUS, 8'h16, "sleep flags");
    $display("test file_sleep done");
  endtask : t_file_sleep

  task automatic test_done;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset_inherent();
    t_control();
    t_arith_ptr();
    t_indirect();
    t_file_sleep();
    test_done();
  end

  initial begin
    #20000;
    errors++;
    test_done();
  end
endmodule : tb_top
